// file: design/ascr_map.vh
// constants for the serial configuration register block
`ifndef ASCR_MAP_VH
`define ASCR_MAP_VH
`define ASCR_CFG_WIDTH 13
`define ASCR_CFG_RESET 13'h0000
`define ASCR_FRAME_BITS 16
`define ASCR_LOAD_BITS 13
`define ASCR_MUX_EDGE 14
`define ASCR_BIT_WRITE 12
`define ASCR_BIT_SEQ 11
`define ASCR_ADDR_HI 10
`define ASCR_ADDR_LO 7
`define ASCR_BIT_PM1 6
`define ASCR_BIT_PM0 5
`define ASCR_BIT_SHADOW 4
`define ASCR_BIT_IDLE 3
`define ASCR_BIT_RANGE 2
`define ASCR_BIT_CODING 1
`define ASCR_BIT_SINGLE 0
`define ASCR_SYS_MHZ 125
`define ASCR_WAKE_NS 1000
`define ASCR_WAKE_CYC ((`ASCR_WAKE_NS * `ASCR_SYS_MHZ + 999) / 1000)
`endif

// file: design/ascr_sync.v
// three-stage pin synchroniser with agreement check
`timescale 1ns/1ps
module ascr_sync #(
  parameter INIT = 1'b0 // idle level of the pin, so reset makes no false edge
) (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg s1; // first stage, read only by s2
  reg s2;
  reg s3;
  // a change counts once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// file: design/ascr_top.v
// serial configuration register of a sixteen channel converter
// Functional notes
// RULE_01 - 13-bit write-only register, loaded on falling edges
// RULE_02 - every transfer uses sixteen serial clocks
// RULE_03 - only first 13 falling edges load
// RULE_04 - bit 12 set enables the write
// RULE_05 - sequence and shadow bits steer sequencer
// RULE_06 - address and mode latched at conversion end
// RULE_07 - in sequence, address is final channel
// RULE_08 - address bits precede twelve result bits; the code sends a leading zero first, so only result bits 11:1 reach the pin
// RULE_09 - multiplexer switches on fourteenth falling edge
// RULE_10 - bits 6:5 select power mode
// RULE_11 - bit 3 picks weak drive or release
// RULE_12 - bit 2 selects input range
// RULE_13 - bit 1 selects output coding
// RULE_14 - bit 0 selects single or differential
// RULE_15 - host avoids double span without supply
// RULE_16 - differential pairs partner by lowest bit
// RULE_17 - auto shutdown needs one microsecond wake
// RULE_18 - shadow write, per-write channel, or sequence
// RULE_19 - control word shifted most significant first
// RULE_20 - register resets to all zeros
`timescale 1ns/1ps
`include "ascr_map.vh"
module ascr_top (
  input wire SYS_CLK,
  input wire SRST,
  input wire SCLK,
  input wire CHIP_SELECT_N,
  input wire DIN,
  input wire [11:0] RESULT,
  output reg DOUT_O,
  output reg DOUT_OE,
  output reg DOUT_WEAK,
  output reg [12:0] CONVERSION_CONFIG,
  output reg [3:0] MUX_POS,
  output reg [3:0] MUX_NEG,
  output reg MUX_DIFF,
  output reg RANGE_REF,
  output reg CODING_BINARY,
  output reg [1:0] POWER_MODE,
  output reg POWERED,
  output reg WAKE_READY,
  output reg SHADOW_ARMED,
  output reg SEQ_ACTIVE,
  output reg [15:0] SHADOW_LIST
);
  localparam ST_IDLE = 2'h0; // waiting for a frame
  localparam ST_SHIFT = 2'h1; // frame running
  localparam ST_DONE = 2'h2; // sixteen edges seen
  localparam integer WAKE_CYC_I = `ASCR_WAKE_CYC; // wake time in cycles
  localparam [7:0] WAKE_CYC = WAKE_CYC_I[7:0];

  wire sclk_s; // synchronised serial clock
  wire csn_s; // synchronised chip select
  wire din_s; // synchronised data in
  reg sclk_d; // previous serial clock level
  reg csn_d; // previous chip select level
  reg [1:0] state; // frame state
  reg [4:0] edge_cnt; // falling edges in this frame
  reg [12:0] shift; // incoming control word
  reg [15:0] out_word; // outgoing address and result
  reg [3:0] conv_addr; // channel being converted now
  reg shadow_next; // next write loads the shadow list
  reg [3:0] seq_ptr; // sequencer position
  reg [7:0] wake_cnt; // wake-up timer
  reg [3:0] next_addr; // channel for next conversion
  reg found; // search helper

  // serial clock and select idle high; reset them high to avoid a false frame
  ascr_sync #(.INIT(1'b1)) u_sclk (.clk(SYS_CLK), .rst(SRST), .din(SCLK),
    .dout(sclk_s));
  ascr_sync #(.INIT(1'b1)) u_csn (.clk(SYS_CLK), .rst(SRST),
    .din(CHIP_SELECT_N), .dout(csn_s));
  ascr_sync u_din (.clk(SYS_CLK), .rst(SRST), .din(DIN), .dout(din_s));

  wire sclk_fall = sclk_d & ~sclk_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire csn_fall = csn_d & ~csn_s;
  wire csn_rise = ~csn_d & csn_s;
  wire [12:0] word_in = {shift[11:0], din_s};

  // next channel from sequencer or the address field
  integer i;
  always @* begin
    next_addr = CONVERSION_CONFIG[`ASCR_ADDR_HI:`ASCR_ADDR_LO];
    found = 1'b0;
    if (SEQ_ACTIVE) begin
      // walk the shadow list upward from the current slot
      for (i = 1; i <= 16; i = i + 1) begin
        if (!found && SHADOW_LIST[seq_ptr + i[3:0]]) begin
          next_addr = seq_ptr + i[3:0]; // RULE_18
          found = 1'b1;
        end
      end
      if (!found) begin
        next_addr = seq_ptr;
      end
    end
  end

  // edge detection on synchronised pins
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sclk_d <= 1'b1;
      csn_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      csn_d <= csn_s;
    end
  end

  // frame engine: shift in config, shift out address then result
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
      edge_cnt <= 5'h00;
      shift <= 13'h0000;
      out_word <= 16'h0000;
      conv_addr <= 4'h0;
      CONVERSION_CONFIG <= `ASCR_CFG_RESET; // RULE_20
      shadow_next <= 1'b0;
      SHADOW_LIST <= 16'h0000;
      SEQ_ACTIVE <= 1'b0;
      seq_ptr <= 4'h0;
      DOUT_O <= 1'b0;
      DOUT_OE <= 1'b0;
      DOUT_WEAK <= 1'b0;
      MUX_POS <= 4'h0;
      MUX_NEG <= 4'h1;
      MUX_DIFF <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (csn_fall) begin
            // sample moment: address leads the output word
            out_word <= {conv_addr, RESULT}; // RULE_08
            DOUT_O <= 1'b0; // leading zero before address
            DOUT_OE <= 1'b1;
            DOUT_WEAK <= 1'b0;
            edge_cnt <= 5'h00;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (csn_rise) begin
            // frame cut short: release output; the store is loaded only if thirteen falls came
            DOUT_OE <= 1'b0;
            state <= ST_IDLE;
          end else if (sclk_fall) begin
            edge_cnt <= edge_cnt + 5'h01;
            if (edge_cnt < `ASCR_LOAD_BITS - 1) begin
              shift <= word_in; // RULE_19
            end else if (edge_cnt == `ASCR_LOAD_BITS - 1) begin
              // thirteenth edge: word complete, later bits ignored
              if (word_in[`ASCR_BIT_WRITE]) begin // RULE_04
                if (shadow_next) begin
                  // list is 16 bits; take the 12 written plus padding
                  SHADOW_LIST <= {word_in[11:0], 4'h0}; // RULE_18
                  shadow_next <= 1'b0;
                  SEQ_ACTIVE <= 1'b1;
                end else begin
                  CONVERSION_CONFIG <= word_in; // RULE_01 RULE_03
                  case ({word_in[`ASCR_BIT_SEQ],
                    word_in[`ASCR_BIT_SHADOW]}) // RULE_05
                    2'b01: begin
                      shadow_next <= 1'b1;
                    end
                    2'b11: begin
                      // consecutive run ending at the address
                      SHADOW_LIST <= 16'hffff >>
                        (4'hf - word_in[10:7]); // RULE_07
                      SEQ_ACTIVE <= 1'b1;
                      seq_ptr <= 4'hf;
                    end
                    2'b10: begin
                      SEQ_ACTIVE <= SEQ_ACTIVE; // RULE_18
                    end
                    default: begin
                      SEQ_ACTIVE <= 1'b0;
                    end
                  endcase
                end
              end
            end else if (edge_cnt == `ASCR_MUX_EDGE - 1) begin
              // fourteenth edge: mux moves to next channel
              conv_addr <= next_addr; // RULE_06 RULE_09
              seq_ptr <= next_addr;
              MUX_POS <= next_addr; // RULE_16
              MUX_NEG <= next_addr ^ 4'h1;
              MUX_DIFF <= ~CONVERSION_CONFIG[`ASCR_BIT_SINGLE]; // RULE_14
            end
            if (edge_cnt == `ASCR_FRAME_BITS - 1) begin
              state <= ST_DONE; // RULE_02
              // idle state of the output after the frame
              if (CONVERSION_CONFIG[`ASCR_BIT_IDLE]) begin // RULE_11
                DOUT_O <= next_addr[3];
                DOUT_WEAK <= 1'b1;
              end else begin
                DOUT_OE <= 1'b0;
              end
            end else begin
              DOUT_O <= out_word[15 - edge_cnt[3:0]];
            end
          end
        end
        ST_DONE: begin
          if (csn_rise) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // range, coding and power follow the stored word
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      RANGE_REF <= 1'b0;
      CODING_BINARY <= 1'b0;
      POWER_MODE <= 2'h0;
      SHADOW_ARMED <= 1'b0;
    end else begin
      RANGE_REF <= CONVERSION_CONFIG[`ASCR_BIT_RANGE]; // RULE_12
      CODING_BINARY <= CONVERSION_CONFIG[`ASCR_BIT_CODING]; // RULE_13
      POWER_MODE <= {CONVERSION_CONFIG[`ASCR_BIT_PM1],
        CONVERSION_CONFIG[`ASCR_BIT_PM0]}; // RULE_10
      SHADOW_ARMED <= shadow_next;
    end
  end

  // power and wake timer; shutdown after each sixteen-fall frame unless mode 11
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      POWERED <= 1'b0;
      WAKE_READY <= 1'b0;
      wake_cnt <= 8'h00;
    end else if (POWER_MODE == 2'h3) begin
      POWERED <= 1'b1; // RULE_17
      WAKE_READY <= 1'b1;
      wake_cnt <= 8'h00;
    end else if (state == ST_DONE) begin
      POWERED <= 1'b0;
      WAKE_READY <= 1'b0;
      wake_cnt <= 8'h00;
    end else if (state == ST_IDLE && !POWERED) begin
      POWERED <= 1'b1;
      wake_cnt <= 8'h00;
    end else if (POWERED && !WAKE_READY) begin
      // count out the wake-up time before conversions are valid
      if (wake_cnt == WAKE_CYC - 8'h01) begin
        WAKE_READY <= 1'b1; // RULE_17
      end else begin
        wake_cnt <= wake_cnt + 8'h01;
      end
    end
  end
endmodule

// file: testbench/ascr_top_sva.sv
// assertion checker for the serial configuration register
`timescale 1ns/1ps
module ascr_top_sva (
  input wire SYS_CLK,
  input wire SRST,
  input wire DOUT_O,
  input wire DOUT_OE,
  input wire DOUT_WEAK,
  input wire [12:0] CONVERSION_CONFIG,
  input wire [3:0] MUX_POS,
  input wire [3:0] MUX_NEG,
  input wire MUX_DIFF,
  input wire RANGE_REF,
  input wire CODING_BINARY,
  input wire [1:0] POWER_MODE,
  input wire SEQ_ACTIVE
);
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  wire [12:0] cfg = CONVERSION_CONFIG; // short alias
  property p_wr; $changed(cfg) |-> cfg[12]; endproperty
  a_wr: assert property (p_wr) else $error("store changed unflagged");
  property p_rst; $fell(SRST) |-> cfg == 13'h0000; endproperty
  a_rst: assert property (p_rst) else $error("store not clear");
  property p_pair; MUX_NEG == (MUX_POS ^ 4'h1); endproperty
  a_pair: assert property (p_pair) else $error("bad pair partner");
  // mux moves one fall after the store, never with it
  property p_late;
    $changed(cfg) && !SEQ_ACTIVE |-> $stable(MUX_POS) && $stable(MUX_DIFF);
  endproperty
  a_late: assert property (p_late) else $error("mux moved early");
  property p_src;
    $changed(MUX_POS) && !SEQ_ACTIVE |->
      MUX_POS == cfg[10:7] && MUX_DIFF == !cfg[0];
  endproperty
  a_src: assert property (p_src) else $error("mux not from store");
  property p_cod; $changed(cfg) |=> CODING_BINARY == cfg[1]; endproperty
  a_cod: assert property (p_cod) else $error("coding wrong");
  property p_rng; $changed(cfg) |=> RANGE_REF == cfg[2]; endproperty
  a_rng: assert property (p_rng) else $error("range wrong");
  property p_pm; $changed(cfg) |-> ##[0:2] POWER_MODE == cfg[6:5]; endproperty
  a_pm: assert property (p_pm) else $error("power mode wrong");
  // weak idle level is the next channel's top address bit
  property p_weak;
    DOUT_WEAK && !SEQ_ACTIVE |-> DOUT_OE && DOUT_O == cfg[10];
  endproperty
  a_weak: assert property (p_weak) else $error("weak idle wrong");
  c_wr: cover property ($changed(cfg));
  c_weak: cover property ($rose(DOUT_WEAK));
  c_mux: cover property ($changed(MUX_POS));
endmodule

// file: testbench/ascr_host.sv
// host serial port model that sends frames into the block
`timescale 1ns/1ps
module ascr_host (
  input wire go,
  input wire [12:0] word,
  input wire [4:0] falls,
  input wire dout,
  output logic sclk,
  output logic cs_n,
  output logic din,
  output logic busy,
  output logic [15:0] rx
);
  integer i;
  initial begin
    sclk = 1'b1; // serial clock stands high outside frames
    cs_n = 1'b1;
    din = 1'b0;
    busy = 1'b0;
    rx = 16'h0000;
  end
  // one frame per go, 80 ns serial period, unrelated to the system clock
  always @(posedge go) begin
    busy = 1'b1;
    cs_n = 1'b0;
    #40;
    for (i = 0; i < falls; i = i + 1) begin
      din = (i < 13) ? word[12 - i] : ~din;
      #40;
      rx = {rx[14:0], dout}; // read the bit standing before its fall
      sclk = 1'b0;
      #40;
      sclk = 1'b1;
    end
    #40;
    cs_n = 1'b1;
    din = ~din; // released line must not keep its last value
    busy = 1'b0;
  end
endmodule

// file: testbench/ascr_top_bench.sv
// self-checking bench for the serial configuration register
`timescale 1ns/1ps
module ascr_top_bench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic [12:0] word = 13'h0000;
  logic [4:0] falls = 5'h10;
  logic [11:0] result = 12'h5a3;
  logic sclk, cs_n, din, busy;
  logic [15:0] rx;
  wire do_o, do_oe, do_wk, diff, rng, cod, pwr, wrdy, arm, seq;
  wire [12:0] cfg;
  wire [3:0] pos, neg;
  wire [1:0] pm;
  wire [15:0] list;
  wire pin = do_oe ? do_o : 1'bz; // driven only while enabled
  integer err_total = 0;
  integer comparisons = 0;
  integer r, k;
  logic [12:0] e, prev;
  // rows: word sent, then store expected after the frame
  logic [25:0] rows [0:3] = '{{13'h12e7, 13'h12e7}, {13'h0ff0, 13'h12e7},
    {13'h1528, 13'h1528}, {13'h17c5, 13'h17c5}};
  always #4 sys_clk = ~sys_clk;
  ascr_top dut_u (.SYS_CLK(sys_clk), .SRST(srst), .SCLK(sclk),
    .CHIP_SELECT_N(cs_n), .DIN(din), .RESULT(result), .DOUT_O(do_o),
    .DOUT_OE(do_oe), .DOUT_WEAK(do_wk), .CONVERSION_CONFIG(cfg),
    .MUX_POS(pos), .MUX_NEG(neg), .MUX_DIFF(diff), .RANGE_REF(rng),
    .CODING_BINARY(cod), .POWER_MODE(pm), .POWERED(pwr),
    .WAKE_READY(wrdy), .SHADOW_ARMED(arm), .SEQ_ACTIVE(seq),
    .SHADOW_LIST(list));
  ascr_host host_u (.go(go), .word(word), .falls(falls), .dout(pin),
    .sclk(sclk), .cs_n(cs_n), .din(din), .busy(busy), .rx(rx));
  task automatic check(input string what, input logic [15:0] exp, got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one frame of n falls; bounded wait, then let the pins settle
  task frame(input logic [12:0] w, input logic [4:0] n);
    @(posedge sys_clk);
    #1;
    word = w;
    falls = n;
    go = 1'b1;
    @(posedge sys_clk);
    #1;
    go = 1'b0;
    for (k = 0; k < 400 && busy; k = k + 1) @(posedge sys_clk);
    if (k == 400) begin
      err_total = err_total + 1;
      print_verdict;
    end
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    check("store", 16'h0000, {3'h0, cfg});
    check("partner", 16'h0001, {12'h000, neg});
    prev = 13'h0000;
    for (r = 0; r < 4; r = r + 1) begin
      result = result + 12'h3c5;
      e = rows[r][12:0];
      frame(rows[r][25:13], 5'h10);
      check("store", {3'h0, e}, {3'h0, cfg});
      check("fields", {1'b0, e[10:7], e[10:7] ^ 4'h1, ~e[0], e[2], e[1],
        e[6:5], e[3], e[3]}, {1'b0, pos, neg, diff, rng, cod, pm, do_oe,
        do_wk});
      check("serial out", {1'b0, prev[10:7], result[11:1]}, rx);
      prev = e;
    end
    // frame cut after ten falls loads nothing
    frame(13'h1fff, 5'h0a);
    check("short frame", {3'h0, prev}, {3'h0, cfg});
    // thirteen falls load the store but leave the mux alone
    frame(13'h1045, 5'h0d);
    check("store", 16'h1045, {3'h0, cfg});
    check("mux held", 16'h000f, {12'h000, pos});
    frame(13'h0000, 5'h10);
    check("mux moved", 16'h0000, {12'h000, pos});
    check("serial out", {5'h0f, result[11:1]}, rx);
    // shadow select, auto shutdown, then the list write starts a sequence
    frame(13'h1015, 5'h10);
    check("armed", 16'h0001, {15'h0000, arm});
    check("wake early", 16'h0002, {14'h0000, pwr, wrdy});
    repeat (130) @(posedge sys_clk);
    check("wake done", 16'h0003, {14'h0000, pwr, wrdy});
    frame(13'h1003, 5'h10);
    check("list", 16'h0030, list);
    check("store", 16'h1015, {3'h0, cfg});
    check("sequence", 16'h0014, {11'h000, seq, pos});
    // reset in mid-run, then a clean frame with no false edge
    srst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    check("reset store", 16'h0000, {3'h0, cfg});
    check("reset mux", 16'h0001, {7'h00, seq, pos, neg});
    frame(13'h12e7, 5'h10);
    check("store", 16'h12e7, {3'h0, cfg});
    print_verdict;
  end
endmodule
bind ascr_top ascr_top_sva chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .DOUT_WEAK(DOUT_WEAK),
  .CONVERSION_CONFIG(CONVERSION_CONFIG), .MUX_POS(MUX_POS),
  .MUX_NEG(MUX_NEG), .MUX_DIFF(MUX_DIFF), .RANGE_REF(RANGE_REF),
  .CODING_BINARY(CODING_BINARY), .POWER_MODE(POWER_MODE),
  .SEQ_ACTIVE(SEQ_ACTIVE));
